// file: hdl/deru_pkg.sv
// constants and types shared by the reorder unit
package deru_pkg;

  // register byte offsets on the wishbone bus
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] MODE_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [7:0] HDCNT_OFS = 8'h0c;

  // data_endian_control fields
  localparam int CTRL_INTR_BIT = 0;
  localparam int CTRL_EXTR_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;

  // mode register fields
  localparam int MODE_LE_BIT = 0;
  localparam int MODE_ORD_BIT = 1;
  localparam logic [1:0] MODE_RST = 2'h1;

  // status register field positions
  localparam int STAT_VALID_POS = 0;
  localparam int STAT_READY_POS = 4;

  // stream element layout
  localparam int WORD_W = 64;
  localparam int DMA_W = 32;
  localparam int IDX_W = 16;
  localparam int IDX_VAL_W = 15;
  localparam int EXT_W = 8;
  localparam int EXT_VAL_W = 7;
  localparam int FIFO_DEPTH = 8;
  localparam int HDCNT_W = 16;

  // hard-decision output serialiser states
  typedef enum logic [2:0] {
    DERU_SER_EMPTY = 3'b001,
    DERU_SER_LOW = 3'b010,
    DERU_SER_HIGH = 3'b100
  } deru_ser_t;

endpackage : deru_pkg

// file: hdl/deru_top.sv
// byte, half-word and bit reorder unit between decoder kernel and dma
//
// Contract
// - little endian, order 0: hard-decision word passes unchanged.
// - little endian, order 1: bits reversed inside each 32-bit half.
// - big endian, order 0: 32-bit halves of hard-decision word exchanged.
// - hard decisions leave as 32-bit words, low group first, then next.
// - control register picks native or packed storage per data type.
// - interleaver index is 16 bits, value in lower 15 bits.
// - extrinsic value is 8 bits, value in lower 7 bits.
// - native interleaver storage: ascending half-word addresses per index.
// - packed interleaver storage: index pairs swapped within each word.
// - big endian interleaver: reorder to kernel order 3,2,1,0.
// - little endian: interleaver and extrinsic data pass unchanged.
// - native extrinsic storage: ascending byte addresses per value.
// - packed extrinsic storage: bytes 3,2,1,0 then 7,6,5,4.
// - big endian packed extrinsic: 32-bit halves exchanged.
// - big endian native extrinsic: all eight byte lanes reversed.
//
// Decided for this implementation: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ns

// synchronous fifo with registered outputs and registered ready
module deru_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] count;

  // pointer advance with wrap at depth
  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : bump

  // handshake and next-state terms
  wire do_wr = in_valid_i & in_ready_o;
  wire do_rd = out_valid_o & out_ready_i;
  wire [CW-1:0] next_count = count + CW'(do_wr) - CW'(do_rd);
  wire [AW-1:0] next_rd = do_rd ? bump(rd_ptr) : rd_ptr;
  wire bypass = do_wr & (wr_ptr == next_rd);

  // storage array
  always_ff @(posedge clk_i) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // pointers, level and registered outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready_o <= 1'b1;
      out_valid_o <= 1'b0;
      out_data_o <= '0;
    end else begin
      wr_ptr <= do_wr ? bump(wr_ptr) : wr_ptr;
      rd_ptr <= next_rd;
      count <= next_count;
      in_ready_o <= (next_count != CW'(DEPTH)); // back-pressure
      out_valid_o <= (next_count != '0);
      out_data_o <= bypass ? in_data_i : mem[next_rd];
    end
  end
endmodule : deru_fifo

// reorder unit top with wishbone register slave
module deru_top #(
  parameter int DEPTH = deru_pkg::FIFO_DEPTH
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic hd_krn_valid_i,
  input wire logic [63:0] hd_krn_data_i,
  output logic hd_krn_ready_o,
  output logic hd_dma_valid_o,
  output logic [31:0] hd_dma_data_o,
  input wire logic hd_dma_ready_i,
  input wire logic il_dma_valid_i,
  input wire logic [63:0] il_dma_data_i,
  output logic il_dma_ready_o,
  output logic il_krn_valid_o,
  output logic [63:0] il_krn_data_o,
  input wire logic il_krn_ready_i,
  input wire logic exw_krn_valid_i,
  input wire logic [63:0] exw_krn_data_i,
  output logic exw_krn_ready_o,
  output logic exw_dma_valid_o,
  output logic [63:0] exw_dma_data_o,
  input wire logic exw_dma_ready_i,
  input wire logic exr_dma_valid_i,
  input wire logic [63:0] exr_dma_data_i,
  output logic exr_dma_ready_o,
  output logic exr_krn_valid_o,
  output logic [63:0] exr_krn_data_o,
  input wire logic exr_krn_ready_i
);
  localparam int W = deru_pkg::WORD_W;
  localparam int H = W / 2;
  localparam int IW = deru_pkg::IDX_W;
  localparam int EW = deru_pkg::EXT_W;
  localparam int NIDX = W / IW; // half-word lanes per word
  localparam int NEXT = W / EW; // byte lanes per word

  // software state
  logic [1:0] ctrl;
  logic [1:0] mode;
  logic [deru_pkg::HDCNT_W-1:0] hd_count;

  // hard-decision serialiser state and the word it is splitting
  deru_pkg::deru_ser_t ser_state;
  deru_pkg::deru_ser_t next_ser;
  logic [W-1:0] ser_hold;

  // output side of the hard-decision fifo
  logic hd_q_valid;
  logic [W-1:0] hd_q_data;

  // dma handshake and fifo pop; a word leaves the fifo only when both
  // halves of the previous one are gone
  wire hd_dma_take = hd_dma_valid_o & hd_dma_ready_i;
  wire ser_empty = (ser_state == deru_pkg::DERU_SER_EMPTY);
  wire ser_low = (ser_state == deru_pkg::DERU_SER_LOW);
  wire ser_high = (ser_state == deru_pkg::DERU_SER_HIGH);
  wire ser_free = ser_empty | (ser_high & hd_dma_take);
  wire hd_pop = ser_free & hd_q_valid;

  // mode and storage-format bits as seen by the reorder logic
  wire little_end = mode[deru_pkg::MODE_LE_BIT];
  wire hd_order = mode[deru_pkg::MODE_ORD_BIT];
  wire intr_native = ctrl[deru_pkg::CTRL_INTR_BIT];
  wire extr_native = ctrl[deru_pkg::CTRL_EXTR_BIT];

  // bus decode; a write lands at the edge that sees ack high
  wire wb_req = wb_cyc_i & wb_stb_i;
  wire wb_take = wb_req & wb_ack_o;
  wire wb_wr = wb_take & wb_we_i & wb_sel_i[0];
  wire hit_ctrl = (wb_adr_i == deru_pkg::CTRL_OFS);
  wire hit_mode = (wb_adr_i == deru_pkg::MODE_OFS);
  wire hit_stat = (wb_adr_i == deru_pkg::STAT_OFS);
  wire hit_hdcnt = (wb_adr_i == deru_pkg::HDCNT_OFS);
  wire wr_ctrl = wb_wr & hit_ctrl;
  wire wr_mode = wb_wr & hit_mode;

  // next register values; only the two low bits exist
  wire [1:0] next_ctrl = wr_ctrl ? wb_dat_i[1:0] : ctrl;
  wire [1:0] next_mode = wr_mode ? wb_dat_i[1:0] : mode;

  // status: some output word pending, room on every input
  wire any_pend = hd_dma_valid_o | il_krn_valid_o | exw_dma_valid_o |
    exr_krn_valid_o;
  wire all_room = hd_krn_ready_o & il_dma_ready_o & exw_krn_ready_o &
    exr_dma_ready_o;
  wire [31:0] stat_word = (32'(any_pend) << deru_pkg::STAT_VALID_POS) |
    (32'(all_room) << deru_pkg::STAT_READY_POS);

  // read data select; unmapped offsets read as zero
  wire [31:0] rd_mux =
    hit_ctrl ? {30'h0, ctrl} :
    hit_mode ? {30'h0, mode} :
    hit_stat ? stat_word :
    hit_hdcnt ? 32'(hd_count) :
    32'h0;

  // bus answer: one ack cycle per request, data registered beside it
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_req & ~wb_ack_o;
      wb_dat_o <= rd_mux;
    end
  end

  // control and mode registers
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ctrl <= deru_pkg::CTRL_RST;
      mode <= deru_pkg::MODE_RST;
    end else begin
      ctrl <= next_ctrl;
      mode <= next_mode;
    end
  end

  // hard-decision lane maps, kernel to dma
  logic [W-1:0] hd_flip;
  logic [W-1:0] hd_half_flip;
  genvar gi;

  // full reversal puts the newest stage in bit 0
  for (gi = 0; gi < W; gi++) begin : g_hd_flip
    assign hd_flip[gi] = hd_krn_data_i[W-1-gi];
  end

  // reversal inside each half, halves stay in place
  for (gi = 0; gi < H; gi++) begin : g_hd_half
    assign hd_half_flip[gi] = hd_krn_data_i[H-1-gi];
    assign hd_half_flip[H+gi] = hd_krn_data_i[W-1-gi];
  end

  // halves exchanged, order inside each half kept
  wire [W-1:0] hd_swap =
    {hd_krn_data_i[H-1:0], hd_krn_data_i[W-1:H]};

  // selection by endian mode and order select
  wire [W-1:0] hd_le = hd_order ? hd_half_flip : hd_krn_data_i;
  wire [W-1:0] hd_be = hd_order ? hd_flip : hd_swap;
  wire [W-1:0] hd_ordered = little_end ? hd_le : hd_be;

  // interleaver lane maps, dma to kernel
  logic [W-1:0] il_rev;

  // half-word lanes reversed for native storage
  for (gi = 0; gi < NIDX; gi++) begin : g_il_rev
    assign il_rev[gi*IW +: IW] = il_dma_data_i[(NIDX-1-gi)*IW +: IW];
  end

  // word halves exchanged for packed storage
  wire [W-1:0] il_swap =
    {il_dma_data_i[H-1:0], il_dma_data_i[W-1:H]};
  wire [W-1:0] il_be = intr_native ? il_rev : il_swap;
  wire [W-1:0] il_ordered = little_end ? il_dma_data_i : il_be;

  // extrinsic lane maps, the same in both directions
  logic [W-1:0] exw_rev;
  logic [W-1:0] exr_rev;

  // byte lanes reversed for native storage
  for (gi = 0; gi < NEXT; gi++) begin : g_ex_rev
    assign exw_rev[gi*EW +: EW] = exw_krn_data_i[(NEXT-1-gi)*EW +: EW];
    assign exr_rev[gi*EW +: EW] = exr_dma_data_i[(NEXT-1-gi)*EW +: EW];
  end

  // word halves exchanged for packed storage
  wire [W-1:0] exw_swap =
    {exw_krn_data_i[H-1:0], exw_krn_data_i[W-1:H]};
  wire [W-1:0] exr_swap =
    {exr_dma_data_i[H-1:0], exr_dma_data_i[W-1:H]};

  // big endian picks by storage format, little endian passes through
  wire [W-1:0] exw_be = extr_native ? exw_rev : exw_swap;
  wire [W-1:0] exr_be = extr_native ? exr_rev : exr_swap;
  wire [W-1:0] exw_ordered = little_end ? exw_krn_data_i : exw_be;
  wire [W-1:0] exr_ordered = little_end ? exr_dma_data_i : exr_be;

  // hard-decision words wait here for the serialiser
  deru_fifo #(
    .WIDTH(W),
    .DEPTH(DEPTH)
  ) u_hd_fifo (
    .clk_i(sys_clk_i),
    .rst_i(rst_i),
    .in_valid_i(hd_krn_valid_i),
    .in_data_i(hd_ordered),
    .in_ready_o(hd_krn_ready_o),
    .out_valid_o(hd_q_valid),
    .out_data_o(hd_q_data),
    .out_ready_i(hd_pop)
  );

  // interleaver words wait here for the kernel
  deru_fifo #(
    .WIDTH(W),
    .DEPTH(DEPTH)
  ) u_il_fifo (
    .clk_i(sys_clk_i),
    .rst_i(rst_i),
    .in_valid_i(il_dma_valid_i),
    .in_data_i(il_ordered),
    .in_ready_o(il_dma_ready_o),
    .out_valid_o(il_krn_valid_o),
    .out_data_o(il_krn_data_o),
    .out_ready_i(il_krn_ready_i)
  );

  // extrinsic words from the kernel wait here for the dma
  deru_fifo #(
    .WIDTH(W),
    .DEPTH(DEPTH)
  ) u_exw_fifo (
    .clk_i(sys_clk_i),
    .rst_i(rst_i),
    .in_valid_i(exw_krn_valid_i),
    .in_data_i(exw_ordered),
    .in_ready_o(exw_krn_ready_o),
    .out_valid_o(exw_dma_valid_o),
    .out_data_o(exw_dma_data_o),
    .out_ready_i(exw_dma_ready_i)
  );

  // extrinsic words from the dma wait here for the kernel
  deru_fifo #(
    .WIDTH(W),
    .DEPTH(DEPTH)
  ) u_exr_fifo (
    .clk_i(sys_clk_i),
    .rst_i(rst_i),
    .in_valid_i(exr_dma_valid_i),
    .in_data_i(exr_ordered),
    .in_ready_o(exr_dma_ready_o),
    .out_valid_o(exr_krn_valid_o),
    .out_data_o(exr_krn_data_o),
    .out_ready_i(exr_krn_ready_i)
  );

  // serialiser next state: low group first, then high group
  always_comb begin
    next_ser = ser_state;
    case (ser_state)
      deru_pkg::DERU_SER_EMPTY: begin
        if (hd_q_valid) begin
          next_ser = deru_pkg::DERU_SER_LOW;
        end
      end
      deru_pkg::DERU_SER_LOW: begin
        if (hd_dma_take) begin
          next_ser = deru_pkg::DERU_SER_HIGH;
        end
      end
      deru_pkg::DERU_SER_HIGH: begin
        if (hd_dma_take && hd_q_valid) begin
          next_ser = deru_pkg::DERU_SER_LOW;
        end else if (hd_dma_take) begin
          next_ser = deru_pkg::DERU_SER_EMPTY;
        end
      end
      default: begin
        next_ser = deru_pkg::DERU_SER_EMPTY;
      end
    endcase
  end

  // next dma word: low group of a fresh word, then its high group
  wire show_high = ser_low & hd_dma_take;
  wire [W-1:0] next_hold = hd_pop ? hd_q_data : ser_hold;
  wire next_hd_valid = (next_ser != deru_pkg::DERU_SER_EMPTY);
  wire [H-1:0] next_hd_data =
    hd_pop ? hd_q_data[H-1:0] :
    show_high ? ser_hold[W-1:H] :
    hd_dma_data_o;
  wire [deru_pkg::HDCNT_W-1:0] next_hd_count =
    hd_dma_take ? hd_count + 1'b1 : hd_count;

  // serialiser registers feeding the dma port; held while stalled
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ser_state <= deru_pkg::DERU_SER_EMPTY;
      ser_hold <= '0;
      hd_dma_valid_o <= 1'b0;
      hd_dma_data_o <= '0;
    end else begin
      ser_state <= next_ser;
      ser_hold <= next_hold;
      hd_dma_valid_o <= next_hd_valid;
      hd_dma_data_o <= next_hd_data;
    end
  end

  // count of words handed to the dma, wraps silently
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      hd_count <= '0;
    end else begin
      hd_count <= next_hd_count;
    end
  end
endmodule : deru_top

// file: test/deru_chk.sv
// port assertions for the reorder unit
`timescale 1ns/1ns
module deru_chk (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic hd_dma_valid_o,
  input wire logic hd_dma_ready_i,
  input wire logic [31:0] hd_dma_data_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // bus answer and dma-side stall behaviour
  ack_one_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack");
  ack_req_a: assert property (wb_ack_o |-> wb_stb_i) else $error("ack");
  ack_soon_a: assert property ($rose(wb_stb_i) |-> ##[0:9] wb_ack_o)
    else $error("ack late");
  ack_idle_a: assert property ((!wb_stb_i) [*2] |-> !wb_ack_o)
    else $error("stray ack");
  hd_keep_a: assert property (hd_dma_valid_o && !hd_dma_ready_i
    |=> hd_dma_valid_o) else $error("word dropped");
  hd_data_a: assert property (hd_dma_valid_o && !hd_dma_ready_i
    |=> $stable(hd_dma_data_o)) else $error("word changed");
  rst_empty_a: assert property ($fell(rst_i) |-> !hd_dma_valid_o)
    else $error("word after reset");
  hd_move_a: assert property ($changed(hd_dma_data_o) && $past(hd_dma_valid_o)
    |-> $past(hd_dma_ready_i)) else $error("word lost");
  cover property (wb_ack_o);
  cover property (hd_dma_valid_o && hd_dma_ready_i);
  cover property (hd_dma_valid_o && !hd_dma_ready_i);
endmodule : deru_chk
bind deru_top deru_chk u_chk (.*);

// file: test/deru_dma.sv
// dma model taking hard-decision words on alternate cycles
`timescale 1ns/1ns
module deru_dma (
  input wire logic clk_i,
  output logic ready_o = 1'b0
);
  // whole words only, stalling every other cycle
  always @(posedge clk_i) ready_o <= ~ready_o;
endmodule : deru_dma

// file: test/deru_top_bench.sv
// bench for registers and streams of the reorder unit
`timescale 1ns/1ns
module deru_top_bench;
  logic sys_clk_i = 0, rst_i = 1, c = 0, we = 0, v = 0;
  logic [7:0] a = '0;
  logic [31:0] wd = '0, rd, hq [$];
  logic [63:0] d = '0, xq [$], ilq [$], ewq [$];
  wire [63:0] id, ed;
  wire iv, ev;
  wire [31:0] wq, hd;
  wire [63:0] xd;
  wire k, r1, r2, r3, r4, hv, dr, xv;
  int n_mismatch = 0, check_count = 0;
  deru_top dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .wb_cyc_i(c),
    .wb_stb_i(c), .wb_we_i(we), .wb_adr_i(a), .wb_sel_i(4'hf),
    .wb_dat_i(wd), .wb_dat_o(wq), .wb_ack_o(k), .hd_krn_valid_i(v),
    .hd_krn_data_i(d), .hd_krn_ready_o(r1), .hd_dma_valid_o(hv),
    .hd_dma_data_o(hd), .hd_dma_ready_i(dr), .il_dma_valid_i(v),
    .il_dma_data_i(d), .il_dma_ready_o(r2), .il_krn_valid_o(iv),
    .il_krn_data_o(id), .il_krn_ready_i(1'b1), .exw_krn_valid_i(v),
    .exw_krn_data_i(d), .exw_krn_ready_o(r3), .exw_dma_valid_o(ev),
    .exw_dma_data_o(ed), .exw_dma_ready_i(dr), .exr_dma_valid_i(v),
    .exr_dma_data_i(d), .exr_dma_ready_o(r4), .exr_krn_valid_o(xv),
    .exr_krn_data_o(xd), .exr_krn_ready_i(1'b1));
  deru_dma m0 (.clk_i(sys_clk_i), .ready_o(dr));
  always #10 sys_clk_i = ~sys_clk_i;
  // collect words leaving on both sides
  always @(posedge sys_clk_i) if (hv && dr) hq.push_back(hd);
  always @(posedge sys_clk_i) if (xv) xq.push_back(xd);
  always @(posedge sys_clk_i) if (iv) ilq.push_back(id);
  always @(posedge sys_clk_i) if (ev && dr) ewq.push_back(ed);
  task chk(input logic [63:0] e, g, input string s);
    check_count++;
    if (g !== e) n_mismatch++;
    if (g !== e) $display("BAD %s exp %h got %h", s, e, g);
  endtask : chk
  task wb(input logic x, input logic [7:0] ad, input logic [31:0] dv);
    @(posedge sys_clk_i);
    {c, we, a, wd} <= {1'b1, x, ad, dv};
    do @(posedge sys_clk_i); while (k !== 1'b1);
    rd = wq;
    c <= 0;
  endtask : wb
  task run(input logic [1:0] m);
    logic [63:0] t, r, e, p;
    t = 64'h0123_4567_89ab_cdef;
    for (int i = 0; i < 64; i++) r[i] = t[63-i];
    e = {<<8{t}};
    wb(1, deru_pkg::MODE_OFS, {30'h0, m});
    wb(1, deru_pkg::CTRL_OFS, {30'h0, m[1], m[1]});
    wb(0, deru_pkg::CTRL_OFS, '0);
    chk({m[1], m[1]}, rd, "ctrl");
    hq.delete();
    xq.delete();
    ilq.delete();
    ewq.delete();
    do @(posedge sys_clk_i); while (!(r1 && r2 && r3 && r4));
    {v, d} <= {1'b1, t};
    do @(posedge sys_clk_i); while (r1 !== 1'b1);
    v <= 0;
    for (int i = 0; i < 60 && (hq.size() < 2 || ewq.size() == 0 ||
         ilq.size() == 0 || xq.size() == 0); i++) @(posedge sys_clk_i);
    r = m[1] ? r : t;
    if (!(m[0] ^ m[1])) r = {r[31:0], r[63:32]};
    if (!m[1]) e = {t[31:0], t[63:32]};
    if (m[0]) e = t;
    p = {t[31:0], t[63:32]};
    if (m[1]) p = {t[15:0], t[31:16], t[47:32], t[63:48]};
    if (m[0]) p = t;
    chk(r[31:0], hq[0], "hd first");
    chk(r[63:32], hq[1], "hd second");
    chk(e, xq[0], "ext");
    chk(p, ilq[0], "intr");
    chk(e, ewq[0], "ext out");
  endtask : run
  task final_report;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  // reset, mode reset value, unmapped read, then every mode
  initial begin
    repeat (3) @(posedge sys_clk_i);
    rst_i <= 0;
    wb(0, deru_pkg::MODE_OFS, '0);
    chk(deru_pkg::MODE_RST, rd, "mode");
    wb(0, 8'h10, '0);
    chk(64'h0, rd, "unmapped");
    for (int m = 0; m < 4; m++) run(m[1:0]);
    wb(0, deru_pkg::HDCNT_OFS, '0);
    chk(64'h8, rd, "hd count");
    wb(0, deru_pkg::STAT_OFS, '0);
    chk(64'h1 << deru_pkg::STAT_READY_POS, rd, "status");
    final_report;
  end
  // hang guard
  initial begin
    #200000;
    n_mismatch++;
    final_report;
  end
endmodule : deru_top_bench
